/* common/flag_irq_pkg.sv */
package flag_irq_pkg;

    // ---------------------------------------------------------------
    // Register offsets and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_REVISION = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h01;
    localparam logic [7:0] REG_LEVELS = 8'h02;
    localparam logic [7:0] REG_MASK = 8'h03;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BIT_WAKE = 7;
    localparam int BIT_SUPPLY = 6;
    localparam int BIT_LDO = 5;
    localparam int BIT_TSD = 4;
    localparam int BIT_TWARN = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BERR = 1;
    localparam int BIT_PIN = 0;
    localparam int BIT_IRQ_EN = 0;
    localparam int BIT_LDO_PG = 1;
    localparam int BIT_BOOST_POWER_GOOD = 0;

    // ---------------------------------------------------------------
    // Target addresses picked by the select pin
    // ---------------------------------------------------------------
    localparam logic [6:0] ADDR_SEL_LOW = 7'h3F;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h2A;

    // ---------------------------------------------------------------
    // Timing, in microseconds, and derived cycle counts
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int SUPPLY_BLANK_US = 1000;
    localparam int LDO_QUAL_US = 125;
    localparam int LDO_MASK_US = 10000;
    localparam int BST_QUAL_US = 125;
    localparam int BST_MASK_US = 10000;
    localparam int IDLE_TICK_US = 100;
    localparam int SUPPLY_BLANK_CYC = SUPPLY_BLANK_US * CLK_MHZ;
    localparam int LDO_QUAL_CYC = LDO_QUAL_US * CLK_MHZ;
    localparam int LDO_MASK_CYC = LDO_MASK_US * CLK_MHZ;
    localparam int BST_QUAL_CYC = BST_QUAL_US * CLK_MHZ;
    localparam int BST_MASK_CYC = BST_MASK_US * CLK_MHZ;
    localparam int IDLE_TICK_CYC = IDLE_TICK_US * CLK_MHZ;
    localparam int IDLE_MULT [4] = '{1, 10, 100, 1000};
    localparam int CNT_W = 24;

    // ---------------------------------------------------------------
    // Serial target phases
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_PTR, PH_DATA, PH_ACK, PH_TX, PH_TXACK
    } phase_t;

endpackage

/* tb/i2c_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host model, open drain on SDA
// ------------------------------------------------------------
module i2c_host_model (
    input wire logic clk, // System clock
    input wire logic sda, // Resolved SDA level
    output logic scl, // Serial clock drive
    output logic sdaPull // High pulls SDA low
);
    // Idle bus: SCL driven high, SDA high through the pull-up
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // Three clk per phase keeps each SCL level over two cycles
    task automatic tick();
        repeat (3) @(negedge clk);
    endtask
    // Start moves SDA only while SCL is high; stop first pulls SDA with SCL low
    task automatic start();
        sdaPull = 1'b0;
        scl = 1'b1;
        tick();
        sdaPull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic stop();
        sdaPull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sdaPull = 1'b0;
        tick();
    endtask
    // MSB first, SDA moves a phase after SCL falls, then target ack
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaPull = ~b[i];
            tick();
            scl = 1'b1;
            tick();
            scl = 1'b0;
            tick();
        end
        sdaPull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        ack = ~sda;
        scl = 1'b0;
        tick();
    endtask
    // Released SDA floats high, so a silent target reads as ones
    task automatic rd_byte(input logic last, output logic [7:0] d);
        sdaPull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            tick();
            scl = 1'b1;
            tick();
            d[i] = sda;
            scl = 1'b0;
        end
        tick();
        sdaPull = ~last;
        tick();
        scl = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
endmodule

/* tb/test_status_flag_interrupt_logic.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for flag collection, masking and interrupt output
// ------------------------------------------------------------
module test_status_flag_interrupt_logic;
    import flag_irq_pkg::*;
    logic clk = 1'b0;
    logic nrst, scl, sdaPull, sdaOe, hostIrq, regulatorFault, thermalFault;
    logic targetAddressSelect, timerWake, supplyLow, supplyLowMonitorOff;
    logic hostRegulatorPowerGood, hostRegulatorOff, thermalShutdown;
    logic thermalWarning, belowExitTemp, boostSwitched, boostOn;
    logic boostPowerGood, sleepRequest, interconnectHigh;
    logic interconnectDriving, sdaOut;
    logic [1:0] trimVoltageBin, hostRegulatorVoltageSel, boostIdleTime;
    logic [3:0] boostVoltageSetting;
    logic [6:0] devAddr;
    wire sdaLine;
    int err_total, n_compared;
    // Pull-up: the line is low only while some party pulls it
    assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;
    always #4 clk = ~clk;
    // Short counts keep the run brief
    status_flag_interrupt_logic #(.BLANK_CYC(20), .LDO_QUAL(5),
        .LDO_MASK(30), .BST_QUAL(5), .BST_MASK(30)) dut (
        .clk, .nrst, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOe,
        .targetAddressSelect, .trimVoltageBin, .timerWake, .supplyLow,
        .supplyLowMonitorOff, .hostRegulatorPowerGood, .hostRegulatorOff,
        .hostRegulatorVoltageSel, .thermalShutdown, .thermalWarning,
        .belowExitTemp, .boostSwitched, .boostOn, .boostPowerGood,
        .boostVoltageSetting, .boostIdleTime, .sleepRequest,
        .interconnectHigh, .interconnectDriving, .hostIrq, .regulatorFault,
        .thermalFault);
    i2c_host_model host (.clk, .sda(sdaLine), .scl, .sdaPull);
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic bit_is(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] val);
        logic a0, a1, a2;
        host.start();
        host.wr_byte({devAddr, 1'b0}, a0);
        host.wr_byte(ptr, a1);
        host.wr_byte(val, a2);
        host.stop();
        bit_is("write ack", 1'b1, a0 & a1 & a2);
    endtask
    // Pointer set by a write, then a burst read from it
    task automatic rd_regs(input logic [7:0] ptr, input int n,
                           input logic [7:0] exp [4]);
        logic a0, a1, a2;
        logic [7:0] d;
        host.start();
        host.wr_byte({devAddr, 1'b0}, a0);
        host.wr_byte(ptr, a1);
        host.stop();
        host.start();
        host.wr_byte({devAddr, 1'b1}, a2);
        for (int i = 0; i < n; i++) begin
            host.rd_byte(i == n - 1, d);
            chk("read data", exp[i], d);
        end
        host.stop();
        bit_is("read ack", 1'b1, a0 & a1 & a2);
    endtask
    task automatic rd1(input logic [7:0] ptr, input logic [7:0] exp);
        rd_regs(ptr, 1, '{exp, 8'h00, 8'h00, 8'h00});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        rd_regs(REG_REVISION, 4, '{8'h80, 8'h00, 8'h00, 8'h00});
        rd1(8'h04, 8'h00);
        wr_reg(REG_REVISION, 8'hFF);
        rd1(REG_REVISION, 8'h80);
        wr_reg(REG_MASK, 8'hA5);
        rd1(REG_MASK, 8'hA5);
    endtask
    task automatic t_thermal();
        wr_reg(REG_MASK, 8'h01);
        thermalShutdown = 1'b1;
        cyc(1);
        {thermalShutdown, timerWake} = 2'b01;
        cyc(1);
        {timerWake, thermalWarning} = 2'b01;
        cyc(1);
        thermalWarning = 1'b0;
        cyc(2);
        bit_is("hostIrq", 1'b1, hostIrq);
        bit_is("thermalFault", 1'b1, thermalFault);
        rd1(REG_FLAGS, 8'h98);
        bit_is("thermalFault", 1'b1, thermalFault);
        bit_is("hostIrq", 1'b0, hostIrq);
        belowExitTemp = 1'b1;
        rd1(REG_FLAGS, 8'h00);
        bit_is("thermalFault", 1'b0, thermalFault);
    endtask
    // Masked flag, enable off, and the maskless pin flag
    task automatic t_gating();
        wr_reg(REG_MASK, 8'h09);
        thermalWarning = 1'b1;
        cyc(1);
        thermalWarning = 1'b0;
        cyc(2);
        bit_is("hostIrq", 1'b0, hostIrq);
        wr_reg(REG_MASK, 8'h01);
        bit_is("hostIrq", 1'b1, hostIrq);
        wr_reg(REG_MASK, 8'hFE);
        bit_is("hostIrq", 1'b0, hostIrq);
        rd1(REG_FLAGS, 8'h08);
        wr_reg(REG_MASK, 8'hFF);
        interconnectHigh = 1'b1;
        cyc(3);
        bit_is("hostIrq", 1'b1, hostIrq);
        interconnectHigh = 1'b0;
        rd1(REG_FLAGS, 8'h01);
        {interconnectHigh, interconnectDriving} = 2'b11;
        rd1(REG_FLAGS, 8'h00);
        {interconnectHigh, interconnectDriving} = 2'b00;
    endtask
    // Live levels, then power loss inside and after the change window
    task automatic t_power();
        {hostRegulatorPowerGood, boostPowerGood} = 2'b11;
        rd1(REG_LEVELS, 8'h00);
        {hostRegulatorOff, boostOn} = 2'b11;
        rd1(REG_LEVELS, 8'h01);
        hostRegulatorOff = 1'b0;
        rd1(REG_LEVELS, 8'h03);
        wr_reg(REG_MASK, 8'h01);
        hostRegulatorVoltageSel = 2'h1;
        boostVoltageSetting = 4'h3;
        cyc(2);
        {hostRegulatorPowerGood, boostPowerGood} = 2'b00;
        cyc(10);
        {hostRegulatorPowerGood, boostPowerGood} = 2'b11;
        rd1(REG_FLAGS, 8'h00);
        {hostRegulatorPowerGood, boostPowerGood} = 2'b00;
        cyc(10);
        {hostRegulatorPowerGood, boostPowerGood} = 2'b11;
        cyc(2);
        bit_is("regulatorFault", 1'b1, regulatorFault);
        bit_is("hostIrq", 1'b1, hostIrq);
        wr_reg(REG_MASK, 8'h23);
        bit_is("hostIrq", 1'b0, hostIrq);
        rd1(REG_FLAGS, 8'h22);
        bit_is("regulatorFault", 1'b0, regulatorFault);
    endtask
    // Idle alert at the 100 us setting, then the supply blanking span
    task automatic t_idle_supply();
        wr_reg(REG_MASK, 8'h01);
        {sleepRequest, boostIdleTime} = 3'b000;
        repeat (20) begin
            boostSwitched = 1'b1;
            cyc(1);
            boostSwitched = 1'b0;
            cyc(1);
        end
        cyc(12400);
        bit_is("hostIrq", 1'b0, hostIrq);
        cyc(200);
        bit_is("hostIrq", 1'b1, hostIrq);
        sleepRequest = 1'b1;
        rd1(REG_FLAGS, 8'h04);
        bit_is("hostIrq", 1'b0, hostIrq);
        {supplyLow, supplyLowMonitorOff} = 2'b10;
        cyc(10);
        bit_is("hostIrq", 1'b0, hostIrq);
        cyc(15);
        bit_is("hostIrq", 1'b1, hostIrq);
        {supplyLow, supplyLowMonitorOff} = 2'b01;
        rd1(REG_FLAGS, 8'h40);
    endtask
    task automatic t_address();
        logic a;
        host.start();
        host.wr_byte({ADDR_SEL_HIGH, 1'b0}, a);
        host.stop();
        bit_is("address ack", 1'b0, a);
        {targetAddressSelect, trimVoltageBin} = 3'b101;
        devAddr = ADDR_SEL_HIGH;
        rd_regs(REG_REVISION, 4, '{8'h40, 8'h00, 8'h03, 8'h01});
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {nrst, err_total, n_compared, trimVoltageBin} = '0;
        trimVoltageBin = 2'h2;
        devAddr = ADDR_SEL_LOW;
        {timerWake, supplyLow, thermalShutdown, thermalWarning} = '0;
        {belowExitTemp, boostSwitched, boostOn, boostPowerGood} = '0;
        {hostRegulatorPowerGood, interconnectHigh} = '0;
        {interconnectDriving, targetAddressSelect} = '0;
        {hostRegulatorOff, supplyLowMonitorOff, sleepRequest} = '1;
        {boostIdleTime, hostRegulatorVoltageSel, boostVoltageSetting} = '0;
        cyc(5);
        nrst = 1'b1;
        cyc(2);
        t_reset_values();
        t_thermal();
        t_gating();
        t_power();
        t_idle_supply();
        t_address();
        end_of_test();
    end
    // Nearly twice the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule

/* verilog/status_flag_interrupt_logic.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Revision byte shows the two-bit trim bin in bits 7-6, zeros below.
// RULE2 - Bit 7 sets on a timer wake from sleep and clears on status read.
// RULE3 - Bit 6 sets on low supply, blanked 1 ms after the monitor is on.
// RULE4 - Bit 5 sets on qualified regulator power loss, masked after change.
// RULE5 - Bit 4 sets on thermal shutdown and clears on status read.
// RULE6 - Bit 3 sets on thermal warning and clears on status read.
// RULE7 - Bit 2 sets when boost idles for the chosen time while on, awake.
// RULE8 - Bit 1 sets on qualified boost power loss, masked after change.
// RULE9 - Bit 0 sets when the interconnect pin is high and not driven.
// RULE10 - Levels bit 1 is regulator power good while the regulator is on.
// RULE11 - Levels bit 0 is boost power good while boost is on, rest zero.
// RULE12 - Mask bits 7-1 suppress the matching flag when set to one.
// RULE13 - A boost power loss interrupts unless its mask bit is set.
// RULE14 - Interrupt output is high for any unmasked flag with bit 0 on.
// RULE15 - A status read ends the regulator and thermal fault states (code: only once regulator power is good, or below exit temp).
// RULE16 - Registers are reached over a serial target with auto-increment.
// RULE17 - The interconnect pin flag has no mask bit.
module status_flag_interrupt_logic #(
    parameter int BLANK_CYC = flag_irq_pkg::SUPPLY_BLANK_CYC,
    parameter int LDO_QUAL = flag_irq_pkg::LDO_QUAL_CYC,
    parameter int LDO_MASK = flag_irq_pkg::LDO_MASK_CYC,
    parameter int BST_QUAL = flag_irq_pkg::BST_QUAL_CYC,
    parameter int BST_MASK = flag_irq_pkg::BST_MASK_CYC,
    parameter int TICK_CYC = flag_irq_pkg::IDLE_TICK_CYC
) (
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic scl, // Serial clock
    input wire logic sdaIn, // Serial data level
    output logic sdaOut, // Serial data drive value
    output logic sdaOe, // Serial data pulls low
    input wire logic targetAddressSelect, // Address select pin
    input wire logic [1:0] trimVoltageBin, // Trim bin fuse
    input wire logic timerWake, // Sleep timer wake pulse
    input wire logic supplyLow, // Supply under threshold
    input wire logic supplyLowMonitorOff, // Supply monitor disable
    input wire logic hostRegulatorPowerGood, // Regulator above limit
    input wire logic hostRegulatorOff, // Regulator disabled
    input wire logic [1:0] hostRegulatorVoltageSel, // Regulator voltage
    input wire logic thermalShutdown, // Die over shutdown
    input wire logic thermalWarning, // Die over warning
    input wire logic belowExitTemp, // Die under exit level
    input wire logic boostSwitched, // Boost switching pulse
    input wire logic boostOn, // Boost enabled
    input wire logic boostPowerGood, // Boost above limit
    input wire logic [3:0] boostVoltageSetting, // Boost voltage
    input wire logic [1:0] boostIdleTime, // Idle alert time select
    input wire logic sleepRequest, // Sleep active
    input wire logic interconnectHigh, // Interconnect pin high
    input wire logic interconnectDriving, // Interconnect driven out
    output logic hostIrq, // Interrupt to host
    output logic regulatorFault, // Regulator fault state
    output logic thermalFault // Thermal fault state
);
    import flag_irq_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        phase_t ph;
        phase_t after;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic nack;
        logic sdaOe;
        logic sclQ;
        logic sdaQ;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [CNT_W-1:0] blank;
        logic [CNT_W-1:0] ldoQual;
        logic [CNT_W-1:0] ldoMask;
        logic [CNT_W-1:0] bstQual;
        logic [CNT_W-1:0] bstMask;
        logic [CNT_W-1:0] idle;
        logic prevSlOff;
        logic prevLdoOff;
        logic [1:0] prevLdoSel;
        logic prevBstOn;
        logic [3:0] prevBstSet;
        logic ldoFault;
        logic tsdFault;
    } state_t;

    state_t s;
    state_t next_s;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic load;
    logic statusRead;
    logic wrMask;
    logic ldoPg;
    logic bstPg;
    logic [6:0] myAddr;
    logic [7:0] rdByte;
    logic [7:0] setEv;
    logic [CNT_W-1:0] idleLoad;

    // ---------------------------------------------------------------
    // Bus edges and readable values
    // ---------------------------------------------------------------
    // Inputs are synchronous, so one stored copy finds the edges
    assign sclRise = scl && !s.sclQ;
    assign sclFall = !scl && s.sclQ;
    assign startCond = scl && s.sclQ && s.sdaQ && !sdaIn; // RULE16
    assign stopCond = scl && s.sclQ && !s.sdaQ && sdaIn; // RULE16
    assign myAddr = targetAddressSelect ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
    assign ldoPg = hostRegulatorPowerGood && !hostRegulatorOff; // RULE10
    assign bstPg = boostPowerGood && boostOn; // RULE11
    assign idleLoad = CNT_W'(TICK_CYC * IDLE_MULT[boostIdleTime]);

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (s.ptr)
            REG_REVISION: rdByte = {trimVoltageBin, 6'h00}; // RULE1
            REG_FLAGS: rdByte = s.flags;
            REG_LEVELS: rdByte = {6'h00, ldoPg, bstPg}; // RULE11
            REG_MASK: rdByte = s.mask;
            default: rdByte = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        load = 1'b0;
        statusRead = 1'b0;
        wrMask = 1'b0;
        next_s.sclQ = scl;
        next_s.sdaQ = sdaIn;
        // Serial target; start and stop win over any bit phase
        if (startCond) begin
            next_s.ph = PH_ADDR;
            next_s.cnt = 4'h0;
            next_s.sdaOe = 1'b0;
        end else if (stopCond) begin
            next_s.ph = PH_IDLE;
            next_s.sdaOe = 1'b0;
        end else if (sclRise) begin
            if (s.ph inside {PH_ADDR, PH_PTR, PH_DATA}) begin
                next_s.shift = {s.shift[6:0], sdaIn};
                next_s.cnt = s.cnt + 4'h1;
            end
            if (s.ph == PH_TXACK) begin
                next_s.nack = sdaIn;
            end
        end else if (sclFall) begin
            unique case (s.ph)
                PH_IDLE: begin
                end
                PH_ADDR: begin
                    if (s.cnt == 4'h8) begin
                        if (s.shift[7:1] == myAddr) begin // RULE16
                            next_s.sdaOe = 1'b1;
                            next_s.after = s.shift[0] ? PH_TX : PH_PTR;
                            next_s.ph = PH_ACK;
                        end else begin
                            next_s.ph = PH_IDLE;
                        end
                    end
                end
                PH_PTR: begin
                    if (s.cnt == 4'h8) begin
                        next_s.ptr = s.shift;
                        next_s.sdaOe = 1'b1;
                        next_s.after = PH_DATA;
                        next_s.ph = PH_ACK;
                    end
                end
                PH_DATA: begin
                    if (s.cnt == 4'h8) begin
                        wrMask = (s.ptr == REG_MASK); // RULE12
                        next_s.ptr = s.ptr + 8'h01; // RULE16
                        next_s.sdaOe = 1'b1;
                        next_s.after = PH_DATA;
                        next_s.ph = PH_ACK;
                    end
                end
                PH_ACK: begin
                    next_s.sdaOe = 1'b0;
                    next_s.cnt = 4'h0;
                    next_s.ph = s.after;
                    load = (s.after == PH_TX);
                end
                PH_TX: begin
                    if (s.cnt == 4'h8) begin
                        next_s.sdaOe = 1'b0;
                        next_s.ph = PH_TXACK;
                    end else begin
                        next_s.shift = {s.shift[6:0], 1'b0};
                        next_s.sdaOe = !s.shift[6];
                        next_s.cnt = s.cnt + 4'h1;
                    end
                end
                PH_TXACK: begin
                    if (s.nack) begin
                        next_s.ph = PH_IDLE;
                    end else begin
                        load = 1'b1;
                    end
                end
            endcase
            // Byte fetch; the pointer steps past each byte sent
            if (load) begin
                next_s.shift = rdByte;
                next_s.sdaOe = !rdByte[7];
                next_s.cnt = 4'h1;
                next_s.ph = PH_TX;
                next_s.ptr = s.ptr + 8'h01; // RULE16
                statusRead = (s.ptr == REG_FLAGS);
            end
        end

        // Supply monitor blanking after the monitor is turned on
        next_s.prevSlOff = supplyLowMonitorOff;
        if (s.prevSlOff && !supplyLowMonitorOff) begin
            next_s.blank = CNT_W'(BLANK_CYC); // RULE3
        end else if (s.blank != '0) begin
            next_s.blank = s.blank - 1'b1;
        end

        // Regulator: qualify the low level, mask after any change
        next_s.prevLdoOff = hostRegulatorOff;
        next_s.prevLdoSel = hostRegulatorVoltageSel;
        if (s.prevLdoOff != hostRegulatorOff
            || s.prevLdoSel != hostRegulatorVoltageSel) begin
            next_s.ldoMask = CNT_W'(LDO_MASK); // RULE4
        end else if (s.ldoMask != '0) begin
            next_s.ldoMask = s.ldoMask - 1'b1;
        end
        if (hostRegulatorPowerGood || hostRegulatorOff) begin
            next_s.ldoQual = CNT_W'(LDO_QUAL);
        end else if (s.ldoQual != '0) begin
            next_s.ldoQual = s.ldoQual - 1'b1;
        end

        // Boost: same scheme as the regulator
        next_s.prevBstOn = boostOn;
        next_s.prevBstSet = boostVoltageSetting;
        if (s.prevBstOn != boostOn
            || s.prevBstSet != boostVoltageSetting) begin
            next_s.bstMask = CNT_W'(BST_MASK); // RULE8
        end else if (s.bstMask != '0) begin
            next_s.bstMask = s.bstMask - 1'b1;
        end
        if (boostPowerGood || !boostOn) begin
            next_s.bstQual = CNT_W'(BST_QUAL);
        end else if (s.bstQual != '0) begin
            next_s.bstQual = s.bstQual - 1'b1;
        end

        // Boost idle timer restarts on every switching pulse
        if (boostSwitched || !boostOn || sleepRequest) begin
            next_s.idle = idleLoad; // RULE7
        end else if (s.idle != '0) begin
            next_s.idle = s.idle - 1'b1;
        end

        // Flag events
        setEv = 8'h00;
        setEv[BIT_WAKE] = timerWake; // RULE2
        setEv[BIT_SUPPLY] = supplyLow && !supplyLowMonitorOff
            && next_s.blank == '0; // RULE3
        setEv[BIT_LDO] = !hostRegulatorOff && !hostRegulatorPowerGood
            && s.ldoQual == '0 && next_s.ldoMask == '0; // RULE4
        setEv[BIT_TSD] = thermalShutdown; // RULE5
        setEv[BIT_TWARN] = thermalWarning; // RULE6
        setEv[BIT_IDLE] = boostOn && !sleepRequest
            && s.idle == '0; // RULE7
        setEv[BIT_BERR] = boostOn && !boostPowerGood
            && s.bstQual == '0 && next_s.bstMask == '0; // RULE8
        setEv[BIT_PIN] = interconnectHigh && !interconnectDriving; // RULE9

        // Clear on read; an event in the read cycle still sets
        next_s.flags = (statusRead ? 8'h00 : s.flags) | setEv; // RULE2
        if (wrMask) begin
            next_s.mask = s.shift; // RULE12
        end

        // Fault states end on a status read once conditions allow
        next_s.ldoFault = setEv[BIT_LDO] || (s.ldoFault
            && !(statusRead && hostRegulatorPowerGood)); // RULE15
        next_s.tsdFault = setEv[BIT_TSD] || (s.tsdFault
            && !(statusRead && belowExitTemp)); // RULE15
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Open drain: only ever pull low; pin flag bit has no mask
    assign sdaOut = 1'b0;
    assign sdaOe = s.sdaOe;
    assign hostIrq = s.mask[BIT_IRQ_EN]
        && |(s.flags & {~s.mask[7:1], 1'b1}); // RULE13 RULE14 RULE17
    assign regulatorFault = s.ldoFault;
    assign thermalFault = s.tsdFault;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence startSeen;
        scl && s.sclQ && s.sdaQ && !sdaIn;
    endsequence

    sequence monitorTurnedOn;
        s.prevSlOff && !supplyLowMonitorOff && !s.flags[BIT_SUPPLY];
    endsequence

    start_to_addr_a: assert property (startSeen |=> s.ph == PH_ADDR) // RULE16
        else $error("start not seen by target");
    supply_blank_a: assert property (monitorTurnedOn |=> // RULE3
        !s.flags[BIT_SUPPLY] [*8]) else $error("supply flag in blank");
    wake_set_a: assert property (timerWake |=> s.flags[BIT_WAKE]) // RULE2
        else $error("wake flag missing");
    shutdown_set_a: assert property (thermalShutdown |=> // RULE5
        s.flags[BIT_TSD] && thermalFault) else $error("shutdown missed");
    warning_set_a: assert property (thermalWarning |=> // RULE6
        s.flags[BIT_TWARN]) else $error("warning flag missing");
    idle_quiet_a: assert property (!boostOn || sleepRequest |=> // RULE7
        !$rose(s.flags[BIT_IDLE])) else $error("idle flag while off");
    pin_flag_a: assert property (interconnectHigh && !interconnectDriving
        |=> s.flags[BIT_PIN]) else $error("pin flag missing"); // RULE9
    read_clear_a: assert property (statusRead && setEv == 8'h00 // RULE2
        |=> s.flags == 8'h00 ##1 s.ph == PH_TX)
        else $error("flags not cleared by read");
    irq_gate_a: assert property (!s.mask[BIT_IRQ_EN] |-> !hostIrq) // RULE14
        else $error("interrupt while disabled");
    pin_unmasked_a: assert property (s.mask[BIT_IRQ_EN] // RULE17
        && s.flags[BIT_PIN] |-> hostIrq) else $error("pin irq lost");
    mask_write_a: assert property (wrMask |=> // RULE12
        s.mask == $past(s.shift)) else $error("mask not written");
    levels_read_a: assert property (s.ptr == REG_LEVELS |-> // RULE10
        rdByte == {6'h00, ldoPg, bstPg}) else $error("levels wrong");
    ldo_exit_a: assert property (statusRead && hostRegulatorPowerGood
        && !setEv[BIT_LDO] |=> !regulatorFault) // RULE15
        else $error("regulator fault kept");

endmodule
